// ==== design/i2cme_pkg.sv ====
// constants for the two-wire master byte engine
// assumes a single 50 MHz system clock
package i2cme_pkg;
	// ************************************************************
	// timing and widths
	// ************************************************************
	localparam int CLK_MHZ = 50;
	localparam int RELOAD_W = 7;
	localparam logic [6:0] RELOAD_RST = 7'h18;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TX_CLOCKS = 4'h9;
	localparam logic [7:0] BYTE_RST = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_TX_LOW,
		ST_TX_HIGH,
		ST_RX_LOW,
		ST_RX_HIGH,
		ST_RS_SDAUP,
		ST_RS_SCLUP,
		ST_RS_HOLD,
		ST_RS_SDALOW
	} i2cme_state_t;
endpackage

// ==== design/i2cme_engine.sv ====
// byte engine of a two-wire bus master: shifting, acknowledge check,
// reception and repeated-start collision watch.
// assumes open-drain pads with pull-ups outside; cpu port on clk.
//
// Our own choices: the strobed register port.
`timescale 1ns/1ps
module i2cme_engine
	import i2cme_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst_b,
	// cpu side
	input wire logic bufWr,
	input wire logic [7:0] bufWrData,
	input wire logic bufRd,
	output logic [7:0] bufRdData,
	input wire logic receiveEnableSet,
	input wire logic repStartReq,
	input wire logic [6:0] rateReloadValue,
	input wire logic writeCollisionClr,
	input wire logic overflowClr,
	input wire logic eventFlagClr,
	input wire logic busCollisionClr,
	output logic bufferFullFlag,
	output logic ackStatusFlag,
	output logic portEventFlag,
	output logic writeCollisionFlag,
	output logic receiveOverflowFlag,
	output logic receiveEnableBit,
	output logic busCollisionFlag,
	output logic busy,
	// bus pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q, sclPrev_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclMeta_q <= 1'b1;
			sclSync_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
			sclPrev_q <= 1'b1;
		end
		else
		begin
			sclMeta_q <= sclIn;
			sclSync_q <= sclMeta_q;
			sdaMeta_q <= sdaIn;
			sdaSync_q <= sdaMeta_q;
			sclPrev_q <= sclSync_q;
		end
	end
	logic sclFall;
	assign sclFall = !sclSync_q && sclPrev_q;

	// ************************************************************
	// state and rate counter
	// ************************************************************
	i2cme_state_t state_q, state_d;
	logic [RELOAD_W-1:0] rateCount_q;
	logic rateLoad, rollover, counting;
	logic [3:0] bitCount_q;
	logic [7:0] shiftReg_q;
	logic collide;
	logic cpuWrite;
	logic sclHigh_q;

	assign counting = state_q != ST_IDLE;
	assign rollover = counting && rateCount_q == '0;
	// a write only lands while nothing is shifting
	assign cpuWrite = bufWr && state_q == ST_IDLE;

	// rate counter held at the reload value in idle; reloaded on every state change except ST_RS_SDAUP to ST_RS_SCLUP,
	// ST_RS_SDALOW to idle and the collisions in ST_RS_SCLUP or on a clock fall in ST_RS_HOLD
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rateCount_q <= RELOAD_RST;
		else if (!counting || rateLoad)
			rateCount_q <= rateReloadValue;
		else if (rateCount_q != '0)
			rateCount_q <= rateCount_q - 7'h01;
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb
	begin
		state_d = state_q;
		rateLoad = 1'b0;
		collide = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				if (cpuWrite)
					state_d = ST_TX_LOW;
				else if (receiveEnableSet)
					state_d = ST_RX_LOW;
				else if (repStartReq)
					state_d = ST_RS_SDAUP;
			end
			ST_TX_LOW:
				if (rollover)
				begin
					state_d = ST_TX_HIGH;
					rateLoad = 1'b1;
				end
			ST_TX_HIGH:
				if (rollover)
				begin
					rateLoad = 1'b1;
					state_d = bitCount_q == TX_CLOCKS - 4'h1 ?
						ST_IDLE : ST_TX_LOW;
				end
			ST_RX_LOW:
				if (rollover)
				begin
					state_d = ST_RX_HIGH;
					rateLoad = 1'b1;
				end
			ST_RX_HIGH:
				if (rollover)
				begin
					rateLoad = 1'b1;
					state_d = bitCount_q == BITS_PER_BYTE - 4'h1 ?
						ST_IDLE : ST_RX_LOW;
				end
			ST_RS_SDAUP:
				if (rollover)
					state_d = ST_RS_SCLUP;
			ST_RS_SCLUP:
				if (sclSync_q)
				begin
					if (!sdaSync_q)
						collide = 1'b1;
					else
					begin
						rateLoad = 1'b1;
						state_d = ST_RS_HOLD;
					end
				end
			ST_RS_HOLD:
				if (sclFall)
					collide = 1'b1;
				else if (rollover)
				begin
					rateLoad = 1'b1;
					if (sclSync_q && sdaSync_q)
						state_d = ST_RS_SDALOW;
					else if (sclSync_q)
						state_d = ST_RS_SDALOW;
					else
						collide = 1'b1;
				end
			ST_RS_SDALOW:
				if (rollover)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		if (collide)
			state_d = ST_IDLE;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// bit counter counts completed clocks of the current byte
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bitCount_q <= 4'h0;
		else if (state_q == ST_IDLE)
			bitCount_q <= 4'h0;
		else if (rollover && (state_q == ST_TX_HIGH ||
			state_q == ST_RX_HIGH))
			bitCount_q <= bitCount_q + 4'h1;
	end

	// ************************************************************
	// shift register and buffer
	// ************************************************************
	logic txDone, rxDone, ninthFall, eighthTxFall;
	assign txDone = state_q == ST_TX_HIGH && rollover &&
		bitCount_q == TX_CLOCKS - 4'h1;
	assign ninthFall = txDone;
	assign eighthTxFall = state_q == ST_TX_HIGH && rollover &&
		bitCount_q == BITS_PER_BYTE - 4'h1;
	assign rxDone = state_q == ST_RX_HIGH && rollover &&
		bitCount_q == BITS_PER_BYTE - 4'h1;

	// tx: msb first, address byte is seven bits then direction
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			shiftReg_q <= BYTE_RST;
		else if (cpuWrite)
			shiftReg_q <= bufWrData;
		else if (state_q == ST_TX_HIGH && rollover)
			shiftReg_q <= {shiftReg_q[6:0], 1'b1};
		else if (state_q == ST_RX_HIGH && rollover)
			shiftReg_q <= {shiftReg_q[6:0], sdaSync_q};
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bufRdData <= BYTE_RST;
		else if (cpuWrite)
			bufRdData <= bufWrData;
		else if (rxDone)
			bufRdData <= {shiftReg_q[6:0], sdaSync_q};
	end

	// ************************************************************
	// flags
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bufferFullFlag <= 1'b0;
		else if (cpuWrite || rxDone)
			bufferFullFlag <= 1'b1;
		else if (eighthTxFall || bufRd)
			bufferFullFlag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ackStatusFlag <= 1'b0;
		else if (ninthFall)
			ackStatusFlag <= sdaSync_q;
	end

	// set wins over a clear arriving in the same cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			portEventFlag <= 1'b0;
		else if (txDone || rxDone)
			portEventFlag <= 1'b1;
		else if (eventFlagClr)
			portEventFlag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			writeCollisionFlag <= 1'b0;
		else if (bufWr && state_q != ST_IDLE)
			writeCollisionFlag <= 1'b1;
		else if (writeCollisionClr)
			writeCollisionFlag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			receiveOverflowFlag <= 1'b0;
		else if (rxDone && bufferFullFlag && !bufRd)
			receiveOverflowFlag <= 1'b1;
		else if (overflowClr)
			receiveOverflowFlag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			receiveEnableBit <= 1'b0;
		else if (state_q == ST_IDLE && !cpuWrite && receiveEnableSet)
			receiveEnableBit <= 1'b1;
		else if (rxDone)
			receiveEnableBit <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busCollisionFlag <= 1'b0;
		else if (collide)
			busCollisionFlag <= 1'b1;
		else if (busCollisionClr)
			busCollisionFlag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busy <= 1'b0;
		else
			busy <= state_d != ST_IDLE;
	end

	// ************************************************************
	// pin drive (open drain: oe high pulls the line low)
	// ************************************************************
	logic sclLow_d, sdaLow_d;
	logic sdaHold_q;
	always_comb
	begin
		sclLow_d = 1'b1;
		sdaLow_d = sdaHold_q;
		unique case (state_d)
			ST_IDLE:
			begin
				// clock held low after a byte; lines free after collision
				// a byte that just ended keeps the clock low until next cmd
				sclLow_d = !collide &&
					(state_q != ST_IDLE || !sclHigh_q);
				sdaLow_d = collide ? 1'b0 : sdaHold_q;
			end
			ST_TX_LOW:
			begin
				sclLow_d = 1'b1;
				sdaLow_d = bitCount_q == BITS_PER_BYTE ? 1'b0
					: !shiftReg_q[7];
				if (state_q == ST_IDLE)
					sdaLow_d = !bufWrData[7];
			end
			ST_TX_HIGH:
				sclLow_d = 1'b0;
			ST_RX_LOW:
			begin
				sclLow_d = 1'b1;
				sdaLow_d = 1'b0;
			end
			ST_RX_HIGH:
			begin
				sclLow_d = 1'b0;
				sdaLow_d = 1'b0;
			end
			ST_RS_SDAUP:
				sdaLow_d = 1'b0;
			ST_RS_SCLUP, ST_RS_HOLD:
			begin
				sclLow_d = 1'b0;
				sdaLow_d = 1'b0;
			end
			ST_RS_SDALOW:
			begin
				sclLow_d = 1'b0;
				sdaLow_d = 1'b1;
			end
		endcase
		// repeated start ends with clock driven low
		if (state_q == ST_RS_SDALOW && state_d == ST_IDLE)
		begin
			sclLow_d = 1'b1;
			sdaLow_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			sdaHold_q <= 1'b0;
			sclHigh_q <= 1'b1;
		end
		else
		begin
			sclOe <= sclLow_d;
			sdaOe <= sdaLow_d;
			sdaHold_q <= sdaLow_d;
			sclHigh_q <= !sclLow_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
		else
		begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
	end

endmodule

// ==== bench/i2cme_props.sv ====
// checker for the byte engine's cpu flags and bus enables
// assumes it is bound to i2cme_engine; one clock domain
`timescale 1ns/1ps
module i2cme_props
(
	// system
	input wire logic clk,
	input wire logic rst_b,
	// cpu side
	input wire logic bufWr,
	input wire logic bufRd,
	input wire logic receiveEnableSet,
	input wire logic repStartReq,
	input wire logic [6:0] rateReloadValue,
	input wire logic bufferFullFlag,
	input wire logic portEventFlag,
	input wire logic writeCollisionFlag,
	input wire logic receiveOverflowFlag,
	input wire logic receiveEnableBit,
	input wire logic busCollisionFlag,
	input wire logic busy,
	// bus enables
	input wire logic sclOe,
	input wire logic sdaOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ****************
	// helpers
	// ****************
	logic rsOn_q;
	logic [7:0] hiCnt_q;
	// repeated start moves data while the clock is high on purpose
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rsOn_q <= 1'b0;
		else if (repStartReq && !busy && !bufWr && !receiveEnableSet)
			rsOn_q <= 1'b1;
		else if (!busy)
			rsOn_q <= 1'b0;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hiCnt_q <= 8'h00;
		else if (busy && !sclOe)
			hiCnt_q <= hiCnt_q + 8'h01;
		else
			hiCnt_q <= 8'h00;
	end
	sequence s_txStart;
		bufWr && !busy;
	endsequence
	sequence s_fullBusy;
		bufferFullFlag && busy && sclOe;
	endsequence
	a_wr_starts: assert property (s_txStart |=> s_fullBusy)
		else $error("write did not start a byte");
	a_wr_collide: assert property (
		bufWr && busy |=> writeCollisionFlag)
		else $error("busy write not flagged");
	a_sda_moves: assert property (!rsOn_q && $changed(sdaOe) |-> sclOe)
		else $error("data moved while clock high");
	a_half_high: assert property (
		$rose(sclOe) && $past(busy) && !rsOn_q
		|-> hiCnt_q == {1'b0, rateReloadValue} + 8'h01)
		else $error("clock high half has wrong length");
	a_byte_hold: assert property (
		sclOe && !busy && !bufWr
		&& !receiveEnableSet && !repStartReq |=> sclOe)
		else $error("clock released while idle");
	a_done_event: assert property (
		$rose(portEventFlag) && !rsOn_q |-> !busy && sclOe)
		else $error("event without halt");
	a_rx_done: assert property (
		$fell(receiveEnableBit)
		|-> bufferFullFlag && portEventFlag && !busy)
		else $error("receive end flags wrong");
	a_rx_ovf: assert property (
		$fell(receiveEnableBit) && $past(bufferFullFlag)
		|-> receiveOverflowFlag)
		else $error("overflow not flagged");
	a_rd_clears: assert property (
		bufRd && !busy |=> !bufferFullFlag)
		else $error("read left buffer full");
	a_rcv_refused: assert property (
		receiveEnableSet && busy
		&& !receiveEnableBit |=> !receiveEnableBit)
		else $error("receive taken while busy");
	a_coll_idle: assert property (
		$rose(busCollisionFlag)
		|-> ##[0:2] (!sclOe && !sdaOe && !busy))
		else $error("collision did not release bus");
endmodule

// ==== bench/i2cme_slave_model.sv ====
// slave on the bus: acknowledges a byte or sends one
// assumes the bench resolves the open-drain lines
`timescale 1ns/1ps
module i2cme_slave_model
(
	// system
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic cntClr,
	input wire logic sendMode,
	input wire logic ack_sequence_enable,
	input wire logic [7:0] sendByte,
	output logic [7:0] seen_q,
	// bus
	input wire logic scl,
	input wire logic sda,
	output logic pull_q
);
	logic sclPrev_q;
	logic [3:0] cnt_q;
	// ****************
	// bit counter
	// ****************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclPrev_q <= 1'b1;
			cnt_q <= 4'h0;
			seen_q <= 8'h00;
			pull_q <= 1'b0;
		end
		else
		begin
			sclPrev_q <= scl;
			if (cntClr)
				cnt_q <= 4'h0;
			else if (scl && !sclPrev_q)
			begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q < 4'h8)
					seen_q <= {seen_q[6:0], sda};
			end
			// data only changes while the clock is low
			if (!scl)
				pull_q <= sendMode ? (cnt_q < 4'h8 && !sendByte[3'h7 - cnt_q[2:0]])
					: (ack_sequence_enable && cnt_q == 4'h8);
		end
	end
endmodule

// ==== bench/testbench.sv ====
// bench for the byte engine with a slave model on the bus
// assumes package, engine, checker and model compiled first
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic bufWr = 1'b0, bufRd = 1'b0, rcvSet = 1'b0, rsReq = 1'b0;
	logic clr = 1'b0, sendMode = 1'b0, ack_sequence_enable = 1'b0, cntClr = 1'b0;
	logic tbSdaPull = 1'b0, tbSclPull = 1'b0;
	logic [7:0] wrData = 8'h00, sendByte = 8'h00;
	logic [7:0] rdData, seen;
	logic full, ackSt, evt, write_collision_flag, ovf, rcvEn, bcol, busy;
	logic sclOe, sdaOe, slvPull, sclO, sdaO;
	// a rival master can hold the clock low through tbSclPull
	wire scl = !(sclOe | tbSclPull);
	wire sda = !(sdaOe | slvPull | tbSdaPull);
	int n_fail = 0;
	int tests_run = 0;
	always #10 clk = !clk;
	// reload 3 gives a 160 ns bus clock
	i2cme_engine dut (.clk(clk), .rst_b(rst_b), .bufWr(bufWr),
		.bufWrData(wrData), .bufRd(bufRd), .bufRdData(rdData),
		.receiveEnableSet(rcvSet), .repStartReq(rsReq),
		.rateReloadValue(7'h03), .writeCollisionClr(clr),
		.overflowClr(clr), .eventFlagClr(clr), .busCollisionClr(clr),
		.bufferFullFlag(full), .ackStatusFlag(ackSt),
		.portEventFlag(evt), .writeCollisionFlag(write_collision_flag),
		.receiveOverflowFlag(ovf), .receiveEnableBit(rcvEn),
		.busCollisionFlag(bcol), .busy(busy), .sclIn(scl), .sclOut(sclO),
		.sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaO), .sdaOe(sdaOe));
	i2cme_slave_model slv_m (.clk(clk), .rst_b(rst_b), .cntClr(cntClr),
		.sendMode(sendMode), .ack_sequence_enable(ack_sequence_enable), .sendByte(sendByte),
		.seen_q(seen), .scl(scl), .sda(sda), .pull_q(slvPull));
	// ****************
	// tasks
	// ****************
	task chkF(input logic got, input logic exp);
	begin
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task chkB(input logic [7:0] got, input logic [7:0] exp);
	begin
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task cpu(input int op, input logic [7:0] d);
	begin
		@(posedge clk);
		wrData <= d;
		bufWr <= (op == 0);
		bufRd <= (op == 1);
		rcvSet <= (op == 2);
		rsReq <= (op == 3);
		@(posedge clk);
		{bufWr, bufRd, rcvSet, rsReq, clr} <= 5'h00;
		#1;
	end
	endtask
	task slv(input logic m, input logic a, input logic [7:0] b);
	begin
		@(posedge clk);
		sendMode <= m;
		ack_sequence_enable <= a;
		sendByte <= b;
		cntClr <= 1'b1;
		clr <= 1'b1;
		@(posedge clk);
		cntClr <= 1'b0;
	end
	endtask
	task idle;
		int i;
	begin
		for (i = 0; i < 3000 && busy !== 1'b0; i++)
		begin
			@(posedge clk);
			#1;
		end
		// a byte that never ends counts against the run
		if (busy !== 1'b0)
		begin
			n_fail++;
			$display("BAD t=%0t busy got=%h exp=%h", $time, busy, 1'b0);
		end
	end
	endtask
	task t_tx(input logic [7:0] b, input logic ack);
	begin
		slv(1'b0, ack, 8'h00);
		cpu(0, b);
		chkF(full, 1'b1);
		cpu(0, ~b);
		chkF(write_collision_flag, 1'b1);
		cpu(2, 8'h00);
		chkF(rcvEn, 1'b0);
		idle;
		chkB(seen, b);
		chkB(rdData, b);
		chkF(ackSt, !ack);
		chkF(evt, 1'b1);
		chkF(full, 1'b0);
		chkF(sclOe, 1'b1);
		$display("tx %h done", b);
	end
	endtask
	task t_rx(input logic [7:0] b, input logic ovfExp);
	begin
		slv(1'b1, 1'b0, b);
		cpu(2, 8'h00);
		chkF(rcvEn, 1'b1);
		cpu(0, 8'h77);
		chkF(write_collision_flag, 1'b1);
		idle;
		chkB(rdData, b);
		chkF(full, 1'b1);
		chkF(evt, 1'b1);
		chkF(rcvEn, 1'b0);
		chkF(ovf, ovfExp);
		chkF(sclOe, 1'b1);
		$display("rx %h done", b);
	end
	endtask
	task t_rs(input logic coll);
	begin
		slv(1'b0, 1'b0, 8'h00);
		tbSdaPull <= coll;
		cpu(3, 8'h00);
		idle;
		chkF(bcol, coll);
		chkF(sclOe, !coll);
		chkF(sdaOe, !coll);
		chkF(sclO | sdaO, 1'b0);
		@(posedge clk);
		tbSdaPull <= 1'b0;
		$display("restart %h done", coll);
	end
	endtask
	// pull a line three cycles after the clock is let go: the
	// engine is then in its hold count with data still released
	task t_rs_mid(input logic pullScl);
	begin
		slv(1'b0, 1'b0, 8'h00);
		cpu(3, 8'h00);
		@(negedge sclOe);
		repeat (3) @(posedge clk);
		tbSclPull <= pullScl;
		tbSdaPull <= !pullScl;
		idle;
		chkF(bcol, pullScl);
		chkF(sclOe, !pullScl);
		chkF(sdaOe, !pullScl);
		@(posedge clk);
		tbSclPull <= 1'b0;
		tbSdaPull <= 1'b0;
		$display("restart mid pull %h done", pullScl);
	end
	endtask
	task t_rd;
	begin
		cpu(1, 8'h00);
		chkF(full, 1'b0);
		$display("read done");
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// ****************
	// sequence
	// ****************
	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_tx(8'ha5, 1'b1);
		t_tx(8'h3c, 1'b0);
		t_rx(8'h96, 1'b0);
		t_rx(8'h5a, 1'b1);
		t_rd;
		t_rs(1'b0);
		t_rs(1'b1);
		t_rs_mid(1'b0);
		t_rs_mid(1'b1);
		finish_test;
	end
	initial
	begin
		#100000;
		n_fail++;
		finish_test;
	end
endmodule
bind i2cme_engine i2cme_props u_props (.clk(clk), .rst_b(rst_b),
	.bufWr(bufWr), .bufRd(bufRd), .receiveEnableSet(receiveEnableSet),
	.repStartReq(repStartReq), .rateReloadValue(rateReloadValue),
	.bufferFullFlag(bufferFullFlag), .portEventFlag(portEventFlag),
	.writeCollisionFlag(writeCollisionFlag),
	.receiveOverflowFlag(receiveOverflowFlag),
	.receiveEnableBit(receiveEnableBit),
	.busCollisionFlag(busCollisionFlag), .busy(busy),
	.sclOe(sclOe), .sdaOe(sdaOe));
